/* core/sgs_pkg.sv */
// Shared constants and types for the safety group supervisor
package sgs_pkg;
   // Sizes of the supervised structure
   localparam int NUM_GRP = 4;          // Safety groups
   localparam int PAIRS_PER_GRP = 2;    // Block input pairs per group
   localparam int CONN_PER_GRP = 2;     // Safety connections per group
   localparam int NUM_PAIR = NUM_GRP * PAIRS_PER_GRP;
   localparam int NUM_CONN = NUM_GRP * CONN_PER_GRP;
   localparam int ADDR_W = 10;          // Node address switch bank width
   localparam int DISC_W = 16;          // Discrepancy counter width
   localparam int RA_W = 8;             // Register byte address width

   // Register byte offsets
   localparam logic [RA_W-1:0] REG_PAIR_CFG = 8'h00;
   localparam logic [RA_W-1:0] REG_DISC_TIME = 8'h04;
   localparam logic [RA_W-1:0] REG_RUN_SW = 8'h08;
   localparam logic [RA_W-1:0] REG_IRQ_STATUS = 8'h0c;
   localparam logic [RA_W-1:0] REG_IRQ_MASK = 8'h10;
   localparam logic [RA_W-1:0] REG_GRP_STATE = 8'h14;
   localparam logic [RA_W-1:0] REG_NODE_ADDR = 8'h18;

   // Field positions
   localparam int CFG_BITS = 4;         // Per-pair field in PAIR_CFG
   localparam int CFG_CONTACT = 2;      // Contact type bit in a pair field
   localparam int ST_BLK = 0;           // Block fault events, one per group
   localparam int ST_LINK = 4;          // Link fault events, one per group
   localparam int ST_ADDR = 8;          // Invalid address event
   localparam int ST_W = 9;
   localparam int GS_ACTIVE = 0;
   localparam int GS_BLK = 4;
   localparam int GS_LINK = 8;
   localparam int GS_OUTERR = 12;
   localparam int NA_VALID = 16;

   // Reset values
   localparam logic [31:0] PAIR_CFG_RST = 32'h0000_0000;
   localparam logic [NUM_GRP-1:0] RUN_SW_RST = 4'hf;
   localparam logic [ST_W-1:0] IRQ_MASK_RST = 9'h000;
   localparam logic [ADDR_W-1:0] ADDR_INVALID = 10'h000;

   // Discrepancy window default, as a time and as clock cycles
   localparam int CLK_PERIOD_NS = 10;
   localparam int DISC_TIME_NS = 1000;
   localparam logic [DISC_W-1:0] DISC_CYC_RST =
      DISC_W'((DISC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Block input modes
   typedef enum logic [1:0]
   {
      SGS_MODE_OFF = 2'b00,
      SGS_MODE_SINGLE = 2'b01,
      SGS_MODE_DUAL = 2'b10
   } sgs_mode_t;

   // Acknowledge pulse tracker states, Gray along low-high-low
   typedef enum logic [1:0]
   {
      SGS_ACK_WAIT_LOW = 2'b00,
      SGS_ACK_SEEN_LOW = 2'b01,
      SGS_ACK_SEEN_HIGH = 2'b11
   } sgs_ack_t;
endpackage : sgs_pkg

/* core/sgs_ack_detect.sv */
// Acknowledge detector: one pulse per low-high-low sequence
`timescale 1ns/1ps
module sgs_ack_detect
   import sgs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ack_level,  // Synchronised acknowledge level
   output logic ack_pulse       // One cycle on the closing falling edge
);
   sgs_ack_t state; // Position in the low-high-low sequence

   // A level held high at reset must first drop, so a stuck-high
   // input can never clear faults by itself
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= SGS_ACK_WAIT_LOW;
      end
      else
      begin
         unique case (state)
            SGS_ACK_WAIT_LOW:
            begin
               if (!ack_level)
                  state <= SGS_ACK_SEEN_LOW;
            end
            SGS_ACK_SEEN_LOW:
            begin
               if (ack_level)
                  state <= SGS_ACK_SEEN_HIGH;
            end
            SGS_ACK_SEEN_HIGH:
            begin
               if (!ack_level)
                  state <= SGS_ACK_SEEN_LOW;
            end
            default:
            begin
               state <= SGS_ACK_WAIT_LOW; // Illegal code recovers
            end
         endcase
      end
   end

   // Pulse registered so it is glitch free
   always_ff @(posedge clk)
   begin
      if (rst)
         ack_pulse <= 1'b0;
      else
         ack_pulse <= (state == SGS_ACK_SEEN_HIGH) && !ack_level;
   end
endmodule : sgs_ack_detect

/* core/sgs_input_pair.sv */
// Block input pair checker with single and two-channel modes
`timescale 1ns/1ps
module sgs_input_pair
   import sgs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,             // Owning group is running
   input wire sgs_mode_t mode,          // Deactivated, single or dual
   input wire logic contact_break,      // Channels expected opposite
   input wire logic ch_a,               // Synchronised channel A
   input wire logic ch_b,               // Synchronised channel B
   input wire logic [DISC_W-1:0] disc_limit, // Window in cycles
   output logic value,                  // Logical input value
   output logic err                     // Discrepancy window exceeded
);
   logic [DISC_W-1:0] disc_cnt; // Cycles spent outside the relation
   logic mismatch;              // Channels break the expected relation

   // Equal levels for make contacts, opposite for break contacts
   assign mismatch = (mode == SGS_MODE_DUAL) &&
                     ((ch_a ^ ch_b) != contact_break);

   // Counts while mismatched; a stopped group holds it cleared
   always_ff @(posedge clk)
   begin
      if (rst || !enable || !mismatch)
         disc_cnt <= '0;
      else if (disc_cnt != disc_limit)
         disc_cnt <= disc_cnt + 1'b1;
   end

   // Error once the mismatch has lasted the whole window
   always_ff @(posedge clk)
   begin
      if (rst || !enable)
         err <= 1'b0;
      else
         err <= mismatch && (disc_cnt == disc_limit);
   end

   // Value per mode; a stopped pair reads as its safe value
   always_ff @(posedge clk)
   begin
      if (rst || !enable)
         value <= 1'b0;
      else
      begin
         unique case (mode)
            SGS_MODE_OFF: value <= 1'b1;
            SGS_MODE_SINGLE: value <= ch_a & ch_b;
            SGS_MODE_DUAL: value <= ch_a & (ch_b ^ contact_break) &
                                    !mismatch;
            default: value <= 1'b0; // Reserved mode code is safe
         endcase
      end
   end
endmodule : sgs_input_pair

/* core/sgs_core.sv */
// Safety group supervisor: address, run gating, fault latching
// Functional notes
// - Node address from ten switches, switch one LSB
// - All-off switches is an invalid address
// - Link fault stops its group only
// - Run true or unlinked executes group blocks
// - Run false stops blocks, outputs safe
// - Acknowledge clears on low-high-low sequence
// - Block fault output while any block errs
// - Link fault output while any connection errs
// - Local output fault flag always false
// - Two-channel pair checks relation within window
// - Single-channel independent, deactivated ignored
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module sgs_core
   import sgs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // Node address switch bank, bit 0 is switch one
   input wire logic [ADDR_W-1:0] addr_sw,
   // Per-group run and acknowledge inputs
   input wire logic [NUM_GRP-1:0] run_in,
   input wire logic [NUM_GRP-1:0] run_linked,
   input wire logic [NUM_GRP-1:0] ack_in,
   // Block input channels and connection error reports
   input wire logic [NUM_PAIR-1:0] ch_a,
   input wire logic [NUM_PAIR-1:0] ch_b,
   input wire logic [NUM_CONN-1:0] conn_err,
   // Register port
   input wire logic [RA_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Results
   output logic [ADDR_W-1:0] node_addr,
   output logic node_addr_valid,
   output logic [NUM_GRP-1:0] grp_active,
   output logic [NUM_GRP-1:0] grp_out,
   output logic [NUM_GRP-1:0] block_fault_flag,
   output logic [NUM_GRP-1:0] link_fault_flag,
   output logic [NUM_GRP-1:0] out_fault_flag,
   output logic irq
);
   // Register address match, used by every access decode
   function automatic logic reg_hit(input logic [RA_W-1:0] a,
                                    input logic [RA_W-1:0] off);
      reg_hit = (a == off);
   endfunction : reg_hit

   localparam int SYNC_W = ADDR_W + 3 * NUM_GRP + 2 * NUM_PAIR + NUM_CONN;

   logic [SYNC_W-1:0] sync1;       // First stage, read only by sync2
   logic [SYNC_W-1:0] sync2;       // Second stage, safe to use
   logic [ADDR_W-1:0] addr_s;      // Synchronised switch bank
   logic [NUM_GRP-1:0] run_s;      // Synchronised run levels
   logic [NUM_GRP-1:0] linked_s;   // Synchronised link-present levels
   logic [NUM_GRP-1:0] ack_s;      // Synchronised acknowledge levels
   logic [NUM_PAIR-1:0] ch_a_s;    // Synchronised channel A
   logic [NUM_PAIR-1:0] ch_b_s;    // Synchronised channel B
   logic [NUM_CONN-1:0] conn_s;    // Synchronised connection errors

   logic [31:0] pair_cfg;          // Mode and contact type per pair
   logic [DISC_W-1:0] disc_time;   // Discrepancy window in cycles
   logic [NUM_GRP-1:0] run_sw;     // Software run enable per group
   logic [ST_W-1:0] irq_status;    // Sticky event bits
   logic [ST_W-1:0] irq_mask;      // Interrupt enables
   logic [ST_W-1:0] events;        // Event pulses this cycle, address bit held as a level
   logic [NUM_GRP-1:0] blk_prev;   // Block fault flag, previous cycle
   logic [NUM_GRP-1:0] link_prev;  // Link fault flag, previous cycle
   logic addr_ok;                  // Decoded address is usable

   logic [NUM_PAIR-1:0] pair_val;  // Per-pair logical value
   logic [NUM_PAIR-1:0] pair_err;  // Per-pair discrepancy error
   logic [NUM_GRP-1:0] blk_cause;  // Any block of the group in error
   logic [NUM_GRP-1:0] link_cause; // Any connection of group in error
   logic [NUM_GRP-1:0] ack_pulse;  // Completed acknowledge sequence
   logic [NUM_GRP-1:0] run_eff;    // Effective run level
   logic [NUM_GRP-1:0] grp_logic;  // AND of the group's pair values
   logic [31:0] next_rdata;        // Read mux result

   // Two-flop synchroniser for every pin input
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= {addr_sw, run_in, run_linked, ack_in, ch_a, ch_b,
                   conn_err};
         sync2 <= sync1;
      end
   end

   assign {addr_s, run_s, linked_s, ack_s, ch_a_s, ch_b_s, conn_s} = sync2;

   // Address is plain binary of the switch bank
   always_ff @(posedge clk)
   begin
      if (rst)
         node_addr <= ADDR_INVALID;
      else
         node_addr <= addr_s;
   end

   // Zero is refused; groups stay stopped until a usable address
   assign addr_ok = (node_addr != ADDR_INVALID);
   assign node_addr_valid = addr_ok;

   // Unlinked run inputs count as true; software may also stop
   assign run_eff = (run_s | ~linked_s) & run_sw;

   // Per-group fault causes, acknowledge and output logic
   genvar g;
   generate
      for (g = 0; g < NUM_GRP; g++)
      begin : g_grp
         assign blk_cause[g] =
            |pair_err[g*PAIRS_PER_GRP +: PAIRS_PER_GRP];
         assign link_cause[g] =
            |conn_s[g*CONN_PER_GRP +: CONN_PER_GRP];
         assign grp_logic[g] =
            &pair_val[g*PAIRS_PER_GRP +: PAIRS_PER_GRP];

         sgs_ack_detect sgs_ack_detect_inst
         (
            .clk(clk),
            .rst(rst),
            .ack_level(ack_s[g]),
            .ack_pulse(ack_pulse[g])
         );
      end
   endgenerate

   // Pair checkers run only while their group is active
   genvar p;
   generate
      for (p = 0; p < NUM_PAIR; p++)
      begin : g_pair
         sgs_input_pair sgs_input_pair_inst
         (
            .clk(clk),
            .rst(rst),
            .enable(grp_active[p / PAIRS_PER_GRP]),
            .mode(sgs_mode_t'(pair_cfg[p*CFG_BITS +: 2])),
            .contact_break(pair_cfg[p*CFG_BITS + CFG_CONTACT]),
            .ch_a(ch_a_s[p]),
            .ch_b(ch_b_s[p]),
            .disc_limit(disc_time),
            .value(pair_val[p]),
            .err(pair_err[p])
         );
      end
   endgenerate

   // Block faults latch; an acknowledge clears only without cause,
   // and a cause in the same cycle keeps the flag set
   always_ff @(posedge clk)
   begin
      if (rst)
         block_fault_flag <= '0;
      else
         block_fault_flag <= blk_cause |
            (block_fault_flag & ~(ack_pulse & ~blk_cause));
   end

   // Link faults latch the same way
   always_ff @(posedge clk)
   begin
      if (rst)
         link_fault_flag <= '0;
      else
         link_fault_flag <= link_cause |
            (link_fault_flag & ~(ack_pulse & ~link_cause));
   end

   // Group runs only with run, a valid address and no link fault;
   // a link fault of one group leaves the others alone
   always_ff @(posedge clk)
   begin
      if (rst)
         grp_active <= '0;
      else
         grp_active <= run_eff & {NUM_GRP{addr_ok}} &
                       ~link_fault_flag & ~link_cause;
   end

   // Group output is forced safe when stopped or faulted; it uses the
   // terms of the next active state so it never lags a stop or fault
   always_ff @(posedge clk)
   begin
      if (rst)
         grp_out <= '0;
      else
         grp_out <= run_eff & {NUM_GRP{addr_ok}} & grp_logic &
                    ~link_fault_flag & ~link_cause &
                    ~block_fault_flag & ~blk_cause;
   end

   // No local outputs exist, so this fault never rises
   always_ff @(posedge clk)
   begin
      if (rst)
         out_fault_flag <= '0;
      else
         out_fault_flag <= '0;
   end

   // Pair configuration register
   always_ff @(posedge clk)
   begin
      if (rst)
         pair_cfg <= PAIR_CFG_RST;
      else if (reg_wr && reg_hit(reg_addr, REG_PAIR_CFG))
         pair_cfg <= reg_wdata;
   end

   // Discrepancy window; zero would flag instantly, so a user
   // should keep it above the channel skew of the sensors
   always_ff @(posedge clk)
   begin
      if (rst)
         disc_time <= DISC_CYC_RST;
      else if (reg_wr && reg_hit(reg_addr, REG_DISC_TIME))
         disc_time <= reg_wdata[DISC_W-1:0];
   end

   // Software run enables, all running after reset
   always_ff @(posedge clk)
   begin
      if (rst)
         run_sw <= RUN_SW_RST;
      else if (reg_wr && reg_hit(reg_addr, REG_RUN_SW))
         run_sw <= reg_wdata[NUM_GRP-1:0];
   end

   // Interrupt mask register
   always_ff @(posedge clk)
   begin
      if (rst)
         irq_mask <= IRQ_MASK_RST;
      else if (reg_wr && reg_hit(reg_addr, REG_IRQ_MASK))
         irq_mask <= reg_wdata[ST_W-1:0];
   end

   // Previous flags for rising-edge event detection
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         blk_prev <= '0;
         link_prev <= '0;
      end
      else
      begin
         blk_prev <= block_fault_flag;
         link_prev <= link_fault_flag;
      end
   end

   // Events: new latched faults, and an invalid address held
   assign events = {!addr_ok,
                    link_fault_flag & ~link_prev,
                    block_fault_flag & ~blk_prev};

   // Sticky status, write one to clear; a new event wins the clear
   always_ff @(posedge clk)
   begin
      if (rst)
         irq_status <= '0;
      else if (reg_wr && reg_hit(reg_addr, REG_IRQ_STATUS))
         irq_status <= (irq_status & ~reg_wdata[ST_W-1:0]) | events;
      else
         irq_status <= irq_status | events;
   end

   assign irq = |(irq_status & irq_mask);

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      next_rdata = '0;
      if (reg_hit(reg_addr, REG_PAIR_CFG))
         next_rdata = pair_cfg;
      else if (reg_hit(reg_addr, REG_DISC_TIME))
         next_rdata[DISC_W-1:0] = disc_time;
      else if (reg_hit(reg_addr, REG_RUN_SW))
         next_rdata[NUM_GRP-1:0] = run_sw;
      else if (reg_hit(reg_addr, REG_IRQ_STATUS))
         next_rdata[ST_W-1:0] = irq_status;
      else if (reg_hit(reg_addr, REG_IRQ_MASK))
         next_rdata[ST_W-1:0] = irq_mask;
      else if (reg_hit(reg_addr, REG_GRP_STATE))
      begin
         next_rdata[GS_ACTIVE +: NUM_GRP] = grp_active;
         next_rdata[GS_BLK +: NUM_GRP] = block_fault_flag;
         next_rdata[GS_LINK +: NUM_GRP] = link_fault_flag;
         next_rdata[GS_OUTERR +: NUM_GRP] = out_fault_flag;
      end
      else if (reg_hit(reg_addr, REG_NODE_ADDR))
      begin
         next_rdata[ADDR_W-1:0] = node_addr;
         next_rdata[NA_VALID] = addr_ok;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (rst || !reg_rd)
         reg_rdata <= '0;
      else
         reg_rdata <= next_rdata;
   end
endmodule : sgs_core

/* verification/sgs_core_checker.sv */
// Concurrent checks on the safety group supervisor pins
`timescale 1ns/1ps
module sgs_core_checker
   import sgs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr_sw,
   input wire logic [NUM_GRP-1:0] ack_in,
   input wire logic [NUM_CONN-1:0] conn_err,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [31:0] reg_rdata,
   input wire logic [ADDR_W-1:0] node_addr,
   input wire logic node_addr_valid,
   input wire logic [NUM_GRP-1:0] grp_active,
   input wire logic [NUM_GRP-1:0] grp_out,
   input wire logic [NUM_GRP-1:0] block_fault_flag,
   input wire logic [NUM_GRP-1:0] link_fault_flag,
   input wire logic [NUM_GRP-1:0] out_fault_flag,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [NUM_GRP-1:0] conn_grp; // Any connection of the group in error
   logic [NUM_GRP-1:0] any_flt;  // Any latched fault of the group
   // Fold connection errors per group
   always_comb
   begin
      for (int g = 0; g < NUM_GRP; g++)
      begin
         conn_grp[g] = conn_err[2*g] | conn_err[2*g+1];
      end
   end
   assign any_flt = block_fault_flag | link_fault_flag;
   addr_follow_a: assert property (
      $stable(addr_sw)[*5] |-> node_addr == addr_sw)
      else $error("node address does not follow switches");
   addr_valid_a: assert property (
      node_addr_valid == (node_addr != '0))
      else $error("address valid flag wrong");
   active_needs_addr_a: assert property (
      (grp_active != '0) |-> $past(node_addr_valid))
      else $error("group active on invalid address");
   link_stops_group_a: assert property (
      (grp_active & link_fault_flag) == '0)
      else $error("group active with link fault");
   // A connection error pin shows as a latched flag three edges on
   link_flag_set_a: assert property (
      (conn_grp != '0) |->
      ##3 ((link_fault_flag & $past(conn_grp, 3)) == $past(conn_grp, 3)))
      else $error("link fault not flagged");
   // Latched flags may only drop four edges after the acknowledge fell
   ack_clear_a: assert property (
      ((($past(any_flt) & ~any_flt)) &
       ($past(ack_in, 4) | ~$past(ack_in, 5))) == '0)
      else $error("fault cleared without acknowledge pulse");
   out_fault_zero_a: assert property (
      out_fault_flag == '0)
      else $error("output fault flag raised");
   out_needs_active_a: assert property (
      (grp_out & ~grp_active) == '0)
      else $error("output enabled on stopped group");
   rdata_idle_a: assert property (
      !$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside read slot");
   irq_drop_a: assert property (
      $fell(irq) |-> $past(reg_wr))
      else $error("interrupt dropped without write");
   cover property ($rose(link_fault_flag[1]));
   cover property ($fell(block_fault_flag[0]));
   cover property ($rose(irq));
endmodule : sgs_core_checker

/* verification/sgs_node_model.sv */
// Behavioural safe input nodes and their connections beyond the groups
`timescale 1ns/1ps
module sgs_node_model
   import sgs_pkg::*;
#(
   // Own node address, distinct from the unit's; value arbitrary
   parameter logic [ADDR_W-1:0] NODE_ID = 10'h2a
)
(
   input wire logic clk,
   input wire logic [NUM_PAIR-1:0] level, // Sensed level per pair
   input wire logic [NUM_PAIR-1:0] brk,   // Break contact, B inverted
   input wire logic [NUM_PAIR-1:0] split, // Channel B faulty on purpose
   input wire logic [NUM_CONN-1:0] fail,  // Connection lost
   output logic [NUM_PAIR-1:0] ch_a,
   output logic [NUM_PAIR-1:0] ch_b,
   output logic [NUM_CONN-1:0] conn_err
);
   // Pins move one edge after the command, like a real node
   always_ff @(posedge clk)
   begin
      ch_a <= level;
      ch_b <= level ^ brk ^ split;
      conn_err <= fail;
   end
endmodule : sgs_node_model

/* verification/sgs_core_tb.sv */
// Self-checking bench for the safety group supervisor
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) \
   begin miscompares++; $display("MISMATCH %s exp %h got %h", nm, ex, \
   got); end end
module sgs_core_tb
   import sgs_pkg::*;
;
   logic clk, rst, reg_wr, reg_rd, node_addr_valid, irq;
   logic [ADDR_W-1:0] addr_sw, node_addr;
   logic [NUM_GRP-1:0] run_in, run_linked, ack_in, grp_active, grp_out;
   logic [NUM_GRP-1:0] block_fault_flag, link_fault_flag, out_fault_flag;
   logic [NUM_PAIR-1:0] ch_a, ch_b, level, brk, split;
   logic [NUM_CONN-1:0] conn_err, fail;
   logic [RA_W-1:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   int miscompares, total_checks;
   logic [ADDR_W-1:0] atab [4] = '{10'h001, 10'h3ff, 10'h200, 10'h000};
   sgs_core sgs_core_inst (.clk(clk), .rst(rst), .addr_sw(addr_sw),
      .run_in(run_in), .run_linked(run_linked), .ack_in(ack_in),
      .ch_a(ch_a), .ch_b(ch_b), .conn_err(conn_err), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .node_addr(node_addr),
      .node_addr_valid(node_addr_valid), .grp_active(grp_active),
      .grp_out(grp_out), .block_fault_flag(block_fault_flag),
      .link_fault_flag(link_fault_flag), .out_fault_flag(out_fault_flag),
      .irq(irq));
   sgs_node_model sgs_node_model_inst (.clk(clk), .level(level),
      .brk(brk), .split(split), .fail(fail), .ch_a(ch_a), .ch_b(ch_b),
      .conn_err(conn_err));
   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Verdict and end of run
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   // One-cycle register write
   task wr(input logic [RA_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read, data taken in the slot after the strobe only
   task rd_chk(input string nm, input logic [RA_W-1:0] a,
      input logic [31:0] ex);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(nm, ex, reg_rdata)
   endtask : rd_chk
   // Wait n edges, then let updates settle
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   // Full low-high-low acknowledge pulse on one group
   task ack(input int g);
      @(posedge clk) ack_in[g] <= 1'b1;
      repeat (3) @(posedge clk);
      ack_in[g] <= 1'b0;
      cyc(6);
   endtask : ack
   // Hang guard, about ten times the some 190 cycles used
   initial
   begin
      #20000;
      miscompares++;
      report_and_stop();
   end
   initial
   begin
      {rst, run_in, run_linked} = '1;
      {reg_wr, reg_rd, ack_in, reg_addr, reg_wdata} = '0;
      {brk, split, fail} = '0;
      level = '1;
      addr_sw = 10'h005;
      miscompares = 0;
      total_checks = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cyc(6);
      rd_chk("disc", REG_DISC_TIME, 32'(DISC_CYC_RST));
      rd_chk("run_sw", REG_RUN_SW, 32'(RUN_SW_RST));
      rd_chk("mask", REG_IRQ_MASK, 32'(IRQ_MASK_RST));
      rd_chk("cfg", REG_PAIR_CFG, PAIR_CFG_RST);
      rd_chk("unmapped", 8'h1c, 32'h0);
      `CHK("outerr", 4'h0, out_fault_flag)
      `CHK("act", 4'hf, grp_active)
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk) addr_sw <= atab[i];
         cyc(6);
         `CHK("addr", atab[i], node_addr)
         `CHK("valid", atab[i] != 0, node_addr_valid)
      end
      `CHK("act_a0", 4'h0, grp_active)
      rd_chk("st_addr", REG_IRQ_STATUS, 32'h100);
      wr(REG_IRQ_MASK, 32'h100);
      cyc(1);
      `CHK("irq_on", 1'b1, irq)
      @(posedge clk) addr_sw <= 10'h005;
      cyc(6);
      wr(REG_IRQ_STATUS, 32'h100);
      cyc(1);
      `CHK("irq_off", 1'b0, irq)
      rd_chk("node", REG_NODE_ADDR, 32'h0001_0005);
      $display("test address done");
      @(posedge clk) run_in <= 4'b0101;
      cyc(6);
      `CHK("act_run", 4'b0101, grp_active)
      `CHK("out_run", 4'b0101, grp_out)
      @(posedge clk) run_linked <= 4'b0011;
      wr(REG_RUN_SW, 32'h7);
      cyc(6);
      `CHK("act_unl", 4'b0101, grp_active)
      @(posedge clk) {run_in, run_linked} <= '1;
      wr(REG_RUN_SW, 32'hf);
      cyc(6);
      $display("test run done");
      @(posedge clk) fail <= 8'h04;
      cyc(6);
      `CHK("link", 4'h2, link_fault_flag)
      `CHK("act_link", 4'hd, grp_active)
      ack(1);
      `CHK("link_busy", 4'h2, link_fault_flag)
      @(posedge clk) fail <= 8'h00;
      cyc(6);
      @(posedge clk) ack_in[1] <= 1'b1;
      cyc(8);
      `CHK("link_half", 4'h2, link_fault_flag)
      @(posedge clk) ack_in[1] <= 1'b0;
      cyc(6);
      `CHK("link_clr", 4'h0, link_fault_flag)
      cyc(4);
      `CHK("act_back", 4'hf, grp_active)
      rd_chk("st_link", REG_IRQ_STATUS, 32'h020);
      wr(REG_IRQ_STATUS, 32'h1ff);
      $display("test link done");
      @(posedge clk) brk <= 8'h10;
      wr(REG_DISC_TIME, 32'h4);
      wr(REG_PAIR_CFG, 32'h0006_0102);
      @(posedge clk) split <= 8'h01;
      @(posedge clk);
      @(posedge clk) split <= 8'h00;
      cyc(12);
      `CHK("blk_short", 4'h0, block_fault_flag)
      @(posedge clk) split <= 8'h45;
      cyc(12);
      `CHK("blk", 4'h1, block_fault_flag)
      `CHK("out_pair", 4'b1100, grp_out)
      rd_chk("gstate", REG_GRP_STATE, 32'h0000_001f);
      @(posedge clk) split <= 8'h00;
      cyc(6);
      `CHK("blk_latch", 4'h1, block_fault_flag)
      ack(0);
      `CHK("blk_clr", 4'h0, block_fault_flag)
      rd_chk("st_blk", REG_IRQ_STATUS, 32'h001);
      $display("test pairs done");
      report_and_stop();
   end
endmodule : sgs_core_tb
bind sgs_core sgs_core_checker sgs_core_checker_inst (.clk(clk),
   .rst(rst), .addr_sw(addr_sw), .ack_in(ack_in), .conn_err(conn_err),
   .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
   .node_addr(node_addr), .node_addr_valid(node_addr_valid),
   .grp_active(grp_active), .grp_out(grp_out),
   .block_fault_flag(block_fault_flag), .link_fault_flag(link_fault_flag),
   .out_fault_flag(out_fault_flag), .irq(irq));
